// *** hdl/pfs_sequencer.sv ***
`timescale 1ns/1ps
module pfs_sequencer
    import pfs_pkg::*;
#(
    parameter bit          AUTO_RETRY   = 1'b1,
    parameter int unsigned RETRY_CYCLES = RETRY_CYCLES_DEF,
    parameter int unsigned BLANK_CYCLES = BLANK_CYCLES_DEF
) (
    input  wire logic sys_clk_in,
    input  wire logic sys_rst_in,
    input  wire logic supply_present_in,
    input  wire logic supply_undervoltage_protect_in,
    input  wire logic enable_shutdown_in,
    input  wire logic undervoltage_lockout_in,
    input  wire logic over_thermal_threshold_in,
    input  wire logic below_hysteresis_in,
    input  wire logic overcurrent_in,
    input  wire logic fast_trip_in,
    input  wire logic ilm_pin_short_in,
    output logic      pass_on_out,
    output logic      current_limit_out,
    output logic      fault_latched_out,
    output logic      fault_indicator_n_out
);

    localparam logic [CNT_W-1:0] DEGLITCH_LOAD = CNT_W'(DEGLITCH_CYCLES - 1);
    localparam logic [CNT_W-1:0] RETRY_LOAD    = CNT_W'(RETRY_CYCLES - 1);

    typedef struct packed {
        pfs_state_e       state;
        logic [CNT_W-1:0] cnt;
        logic             pass_on;
        logic             climit;
        logic             latched;
        logic             fault_n;
    } pfs_seq_s;

    pfs_seq_s st_reg;
    pfs_seq_s st_next;
    logic     blank_expired;
    logic     clear_req;
    logic     run_ok;

    // Blanking also qualifies the pin-short detection, as for overcurrent.
    pfs_blank_timer #(
        .BLANK_CYCLES (BLANK_CYCLES)
    ) u_blank (
        .sys_clk_in     (sys_clk_in),
        .sys_rst_in     (sys_rst_in),
        .overcurrent_in (overcurrent_in | ilm_pin_short_in),
        .expired_out    (blank_expired)
    );

    // Only a full supply loss or enable below the shutdown threshold clears;
    // the shallow undervoltage level is not a clear.
    assign clear_req = !supply_present_in || enable_shutdown_in;
    assign run_ok    = supply_present_in && !supply_undervoltage_protect_in
                       && !enable_shutdown_in && !undervoltage_lockout_in;

    // Next-state logic for the whole sequencer.
    always_comb begin
        st_next = st_reg;
        case (st_reg.state)
            PFS_ST_OFF: begin
                st_next.pass_on = 1'b0;
                st_next.climit  = 1'b0;
                st_next.fault_n = 1'b1;
                if (run_ok && !over_thermal_threshold_in) begin
                    st_next.state   = PFS_ST_ON;
                    st_next.pass_on = 1'b1;
                end
            end
            PFS_ST_ON: begin
                st_next.climit  = overcurrent_in && blank_expired;
                st_next.fault_n = !(overcurrent_in && blank_expired);
                if (over_thermal_threshold_in) begin
                    st_next.state   = PFS_ST_HOT;
                    st_next.pass_on = 1'b0;
                    st_next.climit  = 1'b0;
                    st_next.latched = 1'b1;
                    st_next.fault_n = 1'b0;
                end else if (ilm_pin_short_in && blank_expired) begin
                    st_next.state   = PFS_ST_LATCHED;
                    st_next.pass_on = 1'b0;
                    st_next.climit  = 1'b0;
                    st_next.latched = 1'b1;
                    st_next.fault_n = 1'b0;
                end else if (fast_trip_in) begin
                    st_next.state   = PFS_ST_TRIP_WAIT;
                    st_next.pass_on = 1'b0;
                    st_next.fault_n = 1'b1;
                    st_next.cnt     = DEGLITCH_LOAD;
                end else if (!run_ok) begin
                    st_next.state   = PFS_ST_OFF;
                    st_next.pass_on = 1'b0;
                    st_next.climit  = 1'b0;
                    st_next.fault_n = 1'b1;
                end
            end
            PFS_ST_TRIP_WAIT: begin
                // Output short is not latched; recovery is current limited.
                if (!run_ok || over_thermal_threshold_in) begin
                    st_next.state = PFS_ST_OFF;
                end else if (st_reg.cnt == '0) begin
                    st_next.state   = PFS_ST_ON;
                    st_next.pass_on = 1'b1;
                    st_next.climit  = 1'b1;
                end else begin
                    st_next.cnt = st_reg.cnt - 1'b1;
                end
            end
            PFS_ST_HOT: begin
                // Cooling first; the clear path cannot bypass the hysteresis.
                if (below_hysteresis_in && !over_thermal_threshold_in) begin
                    if (AUTO_RETRY) begin
                        st_next.state = PFS_ST_RETRY;
                        st_next.cnt   = RETRY_LOAD;
                    end else begin
                        st_next.state = PFS_ST_LATCHED;
                    end
                end
            end
            PFS_ST_RETRY: begin
                if (over_thermal_threshold_in) begin
                    st_next.state = PFS_ST_HOT;
                end else if (clear_req) begin
                    st_next.state   = PFS_ST_OFF;
                    st_next.latched = 1'b0;
                    st_next.fault_n = 1'b1;
                    st_next.cnt     = RETRY_LOAD;
                end else if (st_reg.cnt == '0) begin
                    st_next.state   = PFS_ST_OFF;
                    st_next.latched = 1'b0;
                    st_next.fault_n = 1'b1;
                end else begin
                    st_next.cnt = st_reg.cnt - 1'b1;
                end
            end
            PFS_ST_LATCHED: begin
                if (clear_req && !over_thermal_threshold_in) begin
                    st_next.state   = PFS_ST_OFF;
                    st_next.latched = 1'b0;
                    st_next.fault_n = 1'b1;
                end
            end
            default: begin
                st_next.state = PFS_ST_OFF;
            end
        endcase
    end

    // All state registers; reset leaves the switch off and the fault released.
    always_ff @(posedge sys_clk_in) begin
        if (sys_rst_in) begin
            st_reg <= '{state: PFS_ST_OFF, cnt: '0, pass_on: 1'b0,
                        climit: 1'b0, latched: 1'b0,
                        fault_n: FAULT_N_RESET};
        end else begin
            st_reg <= st_next;
        end
    end

    assign pass_on_out           = st_reg.pass_on;
    assign current_limit_out     = st_reg.climit;
    assign fault_latched_out     = st_reg.latched;
    assign fault_indicator_n_out = st_reg.fault_n;

    // Hot die always turns the pass element off on the next edge.
    property p_thermal_off;
        @(posedge sys_clk_in) disable iff (sys_rst_in)
        over_thermal_threshold_in |=> !pass_on_out;
    endproperty
    a_thermal_off: assert property (p_thermal_off)
        else $error("pass element on after thermal trip");

    // Not cooled past hysteresis means still off.
    property p_hot_hold;
        @(posedge sys_clk_in) disable iff (sys_rst_in)
        (st_reg.state == PFS_ST_HOT && !below_hysteresis_in)
            |=> st_reg.state == PFS_ST_HOT && !pass_on_out;
    endproperty
    a_hot_hold: assert property (p_hot_hold)
        else $error("left thermal hold before cooling");

    // Latched state persists without a clear request.
    property p_latch_hold;
        @(posedge sys_clk_in) disable iff (sys_rst_in)
        (st_reg.state == PFS_ST_LATCHED && !clear_req)
            |=> st_reg.state == PFS_ST_LATCHED && !pass_on_out;
    endproperty
    a_latch_hold: assert property (p_latch_hold)
        else $error("latched fault released without clear");

    // Latched fault shows as indicator low.
    property p_fault_low;
        @(posedge sys_clk_in) disable iff (sys_rst_in)
        fault_latched_out |-> !fault_indicator_n_out;
    endproperty
    a_fault_low: assert property (p_fault_low)
        else $error("latched fault with indicator high");

    // Clear from latched releases the indicator next cycle.
    property p_clear;
        @(posedge sys_clk_in) disable iff (sys_rst_in)
        (st_reg.state == PFS_ST_LATCHED && clear_req
            && !over_thermal_threshold_in)
            |=> fault_indicator_n_out && !fault_latched_out;
    endproperty
    a_clear: assert property (p_clear)
        else $error("clear did not release fault");

    // Retry expiry returns to off with the fault released.
    property p_retry;
        @(posedge sys_clk_in) disable iff (sys_rst_in)
        (st_reg.state == PFS_ST_RETRY && st_reg.cnt == '0 && !clear_req
            && !over_thermal_threshold_in)
            |=> st_reg.state == PFS_ST_OFF && fault_indicator_n_out;
    endproperty
    a_retry: assert property (p_retry)
        else $error("retry expiry did not restart");

    // Fast trip turns off and keeps the indicator high.
    property p_fast_trip;
        @(posedge sys_clk_in) disable iff (sys_rst_in)
        (st_reg.state == PFS_ST_ON && fast_trip_in && !ilm_pin_short_in
            && !over_thermal_threshold_in)
            |=> !pass_on_out && fault_indicator_n_out && !fault_latched_out;
    endproperty
    a_fast_trip: assert property (p_fast_trip)
        else $error("fast trip handled wrongly");

    // Overcurrent before blanking expiry never limits.
    property p_no_early_limit;
        @(posedge sys_clk_in) disable iff (sys_rst_in)
        (st_reg.state == PFS_ST_ON && !blank_expired && !fast_trip_in)
            |=> !current_limit_out;
    endproperty
    a_no_early_limit: assert property (p_no_early_limit)
        else $error("current limit before blanking expiry");

    // Retry countdown keeps the switch off and steps once per cycle.
    property p_retry_wait;
        @(posedge sys_clk_in) disable iff (sys_rst_in)
        (st_reg.state == PFS_ST_RETRY && st_reg.cnt != '0 && !clear_req
            && !over_thermal_threshold_in)
            |=> st_reg.state == PFS_ST_RETRY && !pass_on_out
                && st_reg.cnt == $past(st_reg.cnt) - 1'b1;
    endproperty
    a_retry_wait: assert property (p_retry_wait)
        else $error("retry delay not counted while off");

    // A clear during the retry wait drops the fault and reloads the timer.
    property p_retry_clear;
        @(posedge sys_clk_in) disable iff (sys_rst_in)
        (st_reg.state == PFS_ST_RETRY && clear_req
            && !over_thermal_threshold_in)
            |=> st_reg.state == PFS_ST_OFF && !fault_latched_out
                && fault_indicator_n_out && st_reg.cnt == RETRY_LOAD;
    endproperty
    a_retry_clear: assert property (p_retry_clear)
        else $error("clear during retry wait ignored");

    // A shallow enable dip never releases a held fault or the switch.
    property p_undervoltage_lockout_ignored;
        @(posedge sys_clk_in) disable iff (sys_rst_in)
        (fault_latched_out && undervoltage_lockout_in && !clear_req)
            |=> !pass_on_out
                && (fault_latched_out || st_reg.state == PFS_ST_OFF);
    endproperty
    a_undervoltage_lockout_ignored: assert property (p_undervoltage_lockout_ignored)
        else $error("held fault released by enable dip");

    // Cooling past the hysteresis leaves the thermal hold, still off.
    property p_cool_exit;
        @(posedge sys_clk_in) disable iff (sys_rst_in)
        (st_reg.state == PFS_ST_HOT && below_hysteresis_in
            && !over_thermal_threshold_in)
            |=> st_reg.state == (AUTO_RETRY ? PFS_ST_RETRY : PFS_ST_LATCHED)
                && !pass_on_out;
    endproperty
    a_cool_exit: assert property (p_cool_exit)
        else $error("wrong exit from thermal hold");

    // A shorted limit pin past blanking latches off with the fault low.
    property p_pin_short;
        @(posedge sys_clk_in) disable iff (sys_rst_in)
        (st_reg.state == PFS_ST_ON && ilm_pin_short_in && blank_expired
            && !over_thermal_threshold_in)
            |=> st_reg.state == PFS_ST_LATCHED && !pass_on_out
                && fault_latched_out && !fault_indicator_n_out;
    endproperty
    a_pin_short: assert property (p_pin_short)
        else $error("pin short not latched off");

    // Persistent overcurrent limits and lowers the fault, unlatched.
    property p_limit_fault;
        @(posedge sys_clk_in) disable iff (sys_rst_in)
        (st_reg.state == PFS_ST_ON && run_ok && overcurrent_in
            && blank_expired && !ilm_pin_short_in && !fast_trip_in
            && !over_thermal_threshold_in)
            |=> current_limit_out && !fault_indicator_n_out
                && !fault_latched_out;
    endproperty
    a_limit_fault: assert property (p_limit_fault)
        else $error("persistent overcurrent not limited");

    // Deglitch end turns the switch back on under current limiting.
    property p_deglitch;
        @(posedge sys_clk_in) disable iff (sys_rst_in)
        (st_reg.state == PFS_ST_TRIP_WAIT && st_reg.cnt == '0 && run_ok
            && !over_thermal_threshold_in)
            |=> st_reg.state == PFS_ST_ON && pass_on_out
                && current_limit_out;
    endproperty
    a_deglitch: assert property (p_deglitch)
        else $error("no limited turn-on after deglitch");

endmodule

// *** hdl/pfs_pkg.sv ***
package pfs_pkg;

    // Cycle time of the sampling clock in picoseconds.
    localparam int unsigned CLK_PERIOD_PS     = 4000;

    // Fast-trip deglitch interval, in nanoseconds.
    localparam int unsigned DEGLITCH_TIME_NS  = 30000;
    // Least time, so the division rounds up.
    localparam int unsigned DEGLITCH_CYCLES   =
        (DEGLITCH_TIME_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;

    // Default retry delay and blanking interval, in cycles.
    localparam int unsigned RETRY_CYCLES_DEF  = 65536;
    localparam int unsigned BLANK_CYCLES_DEF  = 8192;

    // Width of the shared down counters.
    localparam int unsigned CNT_W             = 20;

    // Level of the fault indicator after reset: released.
    localparam logic        FAULT_N_RESET     = 1'b1;

    // Top-level sequencing states.
    typedef enum logic [2:0] {
        PFS_ST_OFF,
        PFS_ST_ON,
        PFS_ST_TRIP_WAIT,
        PFS_ST_HOT,
        PFS_ST_RETRY,
        PFS_ST_LATCHED
    } pfs_state_e;

endpackage

// *** hdl/pfs_blank_timer.sv ***
`timescale 1ns/1ps
// Overcurrent blanking timer: counts down while overcurrent persists and
// reloads to the full interval as soon as it goes away.
module pfs_blank_timer
    import pfs_pkg::*;
#(
    parameter int unsigned BLANK_CYCLES = BLANK_CYCLES_DEF
) (
    input  wire logic sys_clk_in,
    input  wire logic sys_rst_in,
    input  wire logic overcurrent_in,
    output logic      expired_out
);

    typedef struct packed {
        logic [CNT_W-1:0] cnt;
        logic             expired;
    } pfs_bt_s;

    pfs_bt_s st_reg;
    pfs_bt_s st_next;

    // A short transient restarts the full interval so every event gets it.
    always_comb begin
        st_next = st_reg;
        if (!overcurrent_in) begin
            st_next.cnt     = CNT_W'(BLANK_CYCLES - 1);
            st_next.expired = 1'b0;
        end else if (st_reg.cnt == '0) begin
            st_next.expired = 1'b1;
        end else begin
            st_next.cnt = st_reg.cnt - 1'b1;
        end
    end

    always_ff @(posedge sys_clk_in) begin
        if (sys_rst_in) begin
            st_reg <= '{cnt: CNT_W'(BLANK_CYCLES - 1), expired: 1'b0};
        end else begin
            st_reg <= st_next;
        end
    end

    assign expired_out = st_reg.expired;

endmodule

// *** testbench/pfs_host_model.sv ***
`timescale 1ns/1ps
// Host side of the fault pin: samples the active-low level every cycle
// and counts fault assertions, as a polling controller would.
module pfs_host_model (
    input  wire logic       sys_clk_in,
    input  wire logic       sys_rst_in,
    input  wire logic       fault_indicator_n_in,
    output logic            fault_seen_out,
    output logic [7:0]      fault_events_out
);
    // A low pin is a fault; only falling levels count as new events.
    always_ff @(posedge sys_clk_in) begin
        if (sys_rst_in) begin
            fault_seen_out   <= 1'b0;
            fault_events_out <= 8'h00;
        end else begin
            fault_seen_out <= !fault_indicator_n_in;
            if (!fault_indicator_n_in && !fault_seen_out) begin
                fault_events_out <= fault_events_out + 8'h01;
            end
        end
    end
endmodule

// *** testbench/test_protection_fault_sequencer.sv ***
`timescale 1ns/1ps
// Auto-retry and latch-off variants run side by side on the same inputs.
module test_protection_fault_sequencer;
    import pfs_pkg::*;
    localparam int unsigned RT = 20;
    localparam int unsigned BL = 10;
    logic sys_clk_in = 1'b0;
    logic sys_rst_in = 1'b1;
    logic sup = 1'b1, suv = 1'b0, esd = 1'b0, uvl = 1'b0, hot = 1'b0;
    logic hys = 1'b1, ovc = 1'b0, ftr = 1'b0, current_limit_setting_pin = 1'b0;
    wire  [7:0] obs;
    logic [7:0] exp_q[$];
    logic       chk_req = 1'b0;
    logic       seen;
    logic [7:0] events;
    int error_cnt = 0, tests_run = 0, n = 0, k = 0;

    always #2 sys_clk_in = !sys_clk_in;

    pfs_sequencer #(.AUTO_RETRY(1'b1), .RETRY_CYCLES(RT),
        .BLANK_CYCLES(BL)) u_pfs_sequencer (
        .sys_clk_in(sys_clk_in), .sys_rst_in(sys_rst_in),
        .supply_present_in(sup), .supply_undervoltage_protect_in(suv),
        .enable_shutdown_in(esd), .undervoltage_lockout_in(uvl),
        .over_thermal_threshold_in(hot), .below_hysteresis_in(hys),
        .overcurrent_in(ovc), .fast_trip_in(ftr), .ilm_pin_short_in(current_limit_setting_pin),
        .pass_on_out(obs[7]), .current_limit_out(obs[6]),
        .fault_latched_out(obs[5]), .fault_indicator_n_out(obs[4]));
    // Latch-off variant; its outputs fill the low nibble of obs.
    pfs_sequencer #(.AUTO_RETRY(1'b0), .RETRY_CYCLES(RT),
        .BLANK_CYCLES(BL)) u_pfs_sequencer_lo (
        .sys_clk_in(sys_clk_in), .sys_rst_in(sys_rst_in),
        .supply_present_in(sup), .supply_undervoltage_protect_in(suv),
        .enable_shutdown_in(esd), .undervoltage_lockout_in(uvl),
        .over_thermal_threshold_in(hot), .below_hysteresis_in(hys),
        .overcurrent_in(ovc), .fast_trip_in(ftr), .ilm_pin_short_in(current_limit_setting_pin),
        .pass_on_out(obs[3]), .current_limit_out(obs[2]),
        .fault_latched_out(obs[1]), .fault_indicator_n_out(obs[0]));
    pfs_host_model u_pfs_host_model (
        .sys_clk_in(sys_clk_in), .sys_rst_in(sys_rst_in),
        .fault_indicator_n_in(obs[4]), .fault_seen_out(seen),
        .fault_events_out(events));

    task automatic check(input logic [7:0] got, input logic [7:0] want);
        tests_run++;
        if (got !== want) begin
            error_cnt++;
            $display("[ERR] t=%0t seen=%h expected=%h", $time, got, want);
        end
    endtask

    task automatic summarize();
        $display("comparisons %0d mismatches %0d", tests_run, error_cnt);
        if (error_cnt == 0 && tests_run > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    // Results are compared where outputs have settled, oldest note first.
    always @(negedge sys_clk_in) begin
        if (chk_req) begin
            check(obs, exp_q.pop_front());
            chk_req = 1'b0;
        end
    end

    task automatic note(input logic [7:0] e);
        exp_q.push_back(e);
        chk_req = 1'b1;
        @(negedge sys_clk_in);
        #1;
    endtask

    task automatic cyc(input int c);
        repeat (c) @(posedge sys_clk_in);
        #1;
    endtask

    // Bounded wait for one output bit; running out ends the run.
    task automatic wait_sig(input int idx, input logic lvl, input int lim,
                            output int cnt);
        // Step off the launching edge so the output has settled.
        #1;
        cnt = 0;
        while (obs[idx] !== lvl && cnt < lim) begin
            cyc(1);
            cnt++;
        end
        if (obs[idx] !== lvl) begin
            error_cnt++;
            summarize();
        end
    endtask

    initial begin
        void'($urandom(82081));
        cyc(15);
        note(8'h11);
        @(posedge sys_clk_in) sys_rst_in <= 1'b0;
        wait_sig(7, 1'b1, 5, n);
        note(8'h99);
        // Thermal trip, lockout nudge while hot, then cooling.
        @(posedge sys_clk_in) hot <= 1'b1;
        hys <= 1'b0;
        wait_sig(4, 1'b0, 3, n);
        note(8'h22);
        @(posedge sys_clk_in) hot <= 1'b0;
        uvl <= 1'b1;
        cyc(4);
        @(posedge sys_clk_in) uvl <= 1'b0;
        cyc(30);
        note(8'h22);
        @(posedge sys_clk_in) hys <= 1'b1;
        wait_sig(7, 1'b1, RT + 20, n);
        check(8'(n >= RT), 8'h01);
        note(8'h92);
        // Dropping enable clears the latch-off part.
        @(posedge sys_clk_in) esd <= 1'b1;
        cyc(3);
        note(8'h11);
        @(posedge sys_clk_in) esd <= 1'b0;
        wait_sig(3, 1'b1, 5, n);
        note(8'h99);
        // Second trip cleared by pulling the supply away once cooled,
        // since the thermal hold itself waits for the hysteresis.
        @(posedge sys_clk_in) hot <= 1'b1;
        hys <= 1'b0;
        wait_sig(4, 1'b0, 3, n);
        @(posedge sys_clk_in) hot <= 1'b0;
        hys <= 1'b1;
        sup <= 1'b0;
        cyc(3);
        note(8'h11);
        @(posedge sys_clk_in) sup <= 1'b1;
        wait_sig(3, 1'b1, 5, n);
        note(8'h99);
        // Random overcurrent bursts shorter than the blanking interval.
        for (k = 0; k < 6; k++) begin
            @(posedge sys_clk_in) ovc <= 1'b1;
            cyc(1 + $urandom % (BL - 2));
            @(posedge sys_clk_in) ovc <= 1'b0;
            cyc(2);
            note(8'h99);
        end
        @(posedge sys_clk_in) ovc <= 1'b1;
        wait_sig(4, 1'b0, BL + 8, n);
        check(8'(n >= BL), 8'h01);
        note(8'hcc);
        @(posedge sys_clk_in) ovc <= 1'b0;
        wait_sig(4, 1'b1, 5, n);
        note(8'h99);
        // Fast trip: off at once, back under limiting after deglitch.
        @(posedge sys_clk_in) ftr <= 1'b1;
        @(posedge sys_clk_in) ftr <= 1'b0;
        wait_sig(7, 1'b0, 3, n);
        wait_sig(7, 1'b1, DEGLITCH_CYCLES + 50, n);
        check(8'(n >= DEGLITCH_CYCLES), 8'h01);
        note(8'hdd);
        cyc(4);
        // Shorted limit pin latches after blanking.
        @(posedge sys_clk_in) current_limit_setting_pin <= 1'b1;
        wait_sig(4, 1'b0, BL + 8, n);
        check(8'(n >= BL), 8'h01);
        note(8'h22);
        @(posedge sys_clk_in) current_limit_setting_pin <= 1'b0;
        esd <= 1'b1;
        cyc(3);
        note(8'h11);
        @(posedge sys_clk_in) esd <= 1'b0;
        wait_sig(7, 1'b1, 5, n);
        check(events, 8'h04);
        summarize();
    end
endmodule
